// *** charge_gauge_pkg.sv ***
package charge_gauge_pkg;
    // register map, byte addresses behind the serial interface
    localparam logic [7:0] ADDR_CONTROL     = 8'h60;
    localparam logic [7:0] ADDR_COB         = 8'h61;
    localparam logic [7:0] ADDR_BIAS        = 8'h62;
    localparam logic [7:0] ADDR_ACC_MSB     = 8'h10;
    localparam logic [7:0] ADDR_ACC_LSB     = 8'h11;
    localparam logic [7:0] ADDR_FRAC_HI     = 8'h12;
    localparam logic [7:0] ADDR_FRAC_LO     = 8'h13;
    localparam logic [7:0] ADDR_NOM_MSB     = 8'h68;
    localparam logic [7:0] ADDR_NOM_LSB     = 8'h69;
    localparam logic [7:0] ADDR_AE_FRAC     = 8'h6a;
    localparam logic [7:0] ADDR_SLOPE_BASE  = 8'h6b;
    localparam logic [7:0] ADDR_FULL_SEG3   = 8'h6d;
    localparam logic [7:0] ADDR_BP12        = 8'h7c;
    localparam logic [7:0] ADDR_BP23        = 8'h7d;
    localparam logic [7:0] ADDR_BP34        = 8'h7e;
    localparam int         NUM_CURVES       = 3;
    localparam int         NUM_SEGS         = 4;
    localparam int         NUM_SLOPES       = NUM_CURVES * NUM_SEGS;
    localparam int         CTRL_NEGATIVE_BLANK_ENABLE_BIT    = 0;
    // accumulator: 16-bit count in 6.25uVh plus fraction bits
    localparam int         FRAC_W           = 12;
    localparam int         ACC_W            = 16 + FRAC_W;
    localparam logic [15:0] ACC_MAX         = 16'h7fff;
    localparam logic [15:0] ACC_MIN         = 16'h8000;
    // blanking thresholds in 1.5625uV current steps
    localparam logic signed [16:0] CHG_BLANK  = 17'sh00040;
    localparam logic signed [16:0] DIS_BLANK  = -17'sh00010;
    localparam logic signed [7:0]  TEMP_TOP   = 8'sh28;
    localparam int         SLOPE_SHIFT      = 14;
    localparam int         SUM_W            = 16;
    localparam int         CONV_PERIOD_MS   = 3515;
    localparam int         CLK_KHZ          = 25000;
    localparam int         CONV_CYCLES      = CONV_PERIOD_MS * CLK_KHZ;
    localparam int         SAVE_CONVS       = 1024;
    localparam logic [7:0] RESET_BYTE       = 8'h00;

    typedef struct packed {
        logic [15:0] acc;
        logic [7:0]  bias;
    } nv_image_t;

    typedef struct packed {
        logic [15:0] full_cap;
        logic [15:0] active_empty_cap;
        logic [15:0] standby_empty_cap;
    } curve_caps_t;

    typedef enum logic [0:0] {
        WALK_IDLE = 1'b0,
        WALK_STEP = 1'b1
    } walk_state_t;
endpackage : charge_gauge_pkg

// *** charge_gauge.sv ***
// How it works
// - every finished conversion except the first after a write adds its signed result into accumulated_charge
// - count is 16 bits of 6.25uVh, spanning 409.6mVh
// - fraction bits kept apart and readable so truncation loses nothing
// - accumulator clamps at 7fff on charge and 8000 on discharge
// - any accumulator write clears the fraction bits
// - accumulator write asks the converter for an offset correction conversion
// - after a write, accumulation restarts at the second conversion
// - count saved periodically to nonvolatile memory, restored at power-up
// - programmable signed bias added once per conversion, current weighting
// - bias loaded from nonvolatile memory at power-up
// - charge results under 100uV (raw plus offset bias) are always dropped
// - discharge results under 25uV dropped only while negative blanking enabled
// - full, active empty and standby empty curves, five segments each
// - above +40C every curve stays flat at its +40C value
// - segment four ends at +40C, segment one runs to any cold temperature
// - junction temperatures programmable per degree, -128C to +40C
// - junctions coldest to warmest held signed at 7c, 7d, 7e
// - slope step is 61ppm per degree of the +40C value, 0..15555ppm
// - full curve segment three slope sits at 6d
// - curves rebuilt from breakpoints and slopes one degree at a time
// - a new current result arrives once per 3.515s
// - accumulated value is raw result plus current_offset_bias
`timescale 1ns/1ps
`default_nettype none
module charge_gauge
    import charge_gauge_pkg::*;
#(
    parameter int WR_WINDOW_CYCLES = CONV_CYCLES,
    parameter int SAVE_PERIOD      = SAVE_CONVS
) (
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    input  wire logic              conv_done,
    input  wire logic [15:0]       raw_current,
    input  wire logic signed [7:0] temperature,
    input  wire nv_image_t         nv_restore,
    output logic                   nv_save,
    output nv_image_t              nv_save_data,
    output logic                   offset_cal_req,
    output curve_caps_t            curve_caps
);
    logic [15:0]             accumulated_charge_ff;
    logic [FRAC_W-1:0]       charge_fraction_low_ff;
    logic [7:0]              accumulation_bias_ff;
    logic [7:0]              current_offset_bias_ff;
    logic [7:0]              control_ff;
    logic [7:0]              acc_msb_hold_ff;
    logic                    msb_pending_ff;
    logic [31:0]             wr_window_ff;
    logic [1:0]              skip_ff;
    logic                    restored_ff;
    logic [7:0]              slope_ff [NUM_SLOPES];
    logic signed [7:0]       bp_ff [3];
    logic [15:0]             nominal_ff;
    logic [7:0]              ae_frac_ff;
    logic [31:0]             save_cnt_ff;
    logic [7:0]              reg_rdata_ff;
    logic                    acc_write;
    logic signed [16:0]      measured;
    logic signed [16:0]      blanked;
    logic signed [ACC_W+2:0] nxt_acc;
    logic negative_blank_enable;

    assign negative_blank_enable = control_ff[CTRL_NEGATIVE_BLANK_ENABLE_BIT];
    assign acc_write = reg_wr && reg_addr == ADDR_ACC_LSB && msb_pending_ff;

    // power-up restore happens one edge after release, never inside the reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            restored_ff <= 1'b0;
        end else begin
            restored_ff <= 1'b1;
        end
    end

    always_comb begin
        measured = $signed({raw_current[15], raw_current})
                 + $signed({{9{current_offset_bias_ff[7]}}, current_offset_bias_ff});
        blanked = measured;
        if (measured > 17'sh00000 && measured < CHG_BLANK) begin
            blanked = '0;
        end
        if (negative_blank_enable && measured < 17'sh00000 && measured > DIS_BLANK) begin
            blanked = '0;
        end
        // result and bias share the 1.5625uV weight; 2^12 steps make one count
        nxt_acc = $signed({{3{accumulated_charge_ff[15]}}, accumulated_charge_ff,
                           charge_fraction_low_ff})
                + $signed({{(ACC_W-14){blanked[16]}}, blanked})
                + $signed({{(ACC_W-5){accumulation_bias_ff[7]}}, accumulation_bias_ff});
    end

    // accumulator, its fraction and the two-byte host write
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            accumulated_charge_ff  <= '0;
            charge_fraction_low_ff <= '0;
            accumulation_bias_ff   <= RESET_BYTE;
            acc_msb_hold_ff        <= RESET_BYTE;
            msb_pending_ff         <= 1'b0;
            wr_window_ff           <= '0;
            skip_ff                <= '0;
        end else if (!restored_ff) begin
            accumulated_charge_ff <= nv_restore.acc;
            accumulation_bias_ff  <= nv_restore.bias;
        end else begin
            if (reg_wr && reg_addr == ADDR_BIAS) begin
                accumulation_bias_ff <= reg_wdata;
            end
            if (reg_wr && reg_addr == ADDR_ACC_MSB) begin
                acc_msb_hold_ff <= reg_wdata;
                msb_pending_ff  <= 1'b1;
                wr_window_ff    <= '0;
            end else if (acc_write) begin
                msb_pending_ff <= 1'b0;
            end else if (msb_pending_ff) begin
                // a stale high byte is dropped after one update period
                wr_window_ff <= wr_window_ff + 32'h1;
                if (wr_window_ff >= 32'(WR_WINDOW_CYCLES - 1)) begin
                    msb_pending_ff <= 1'b0;
                end
            end
            if (acc_write) begin
                accumulated_charge_ff  <= {acc_msb_hold_ff, reg_wdata};
                charge_fraction_low_ff <= '0;
                skip_ff                <= 2'h1;
            end else if (conv_done) begin
                if (skip_ff != 2'h0) begin
                    skip_ff <= skip_ff - 2'h1;
                end else if (nxt_acc > $signed({3'b000, ACC_MAX, {FRAC_W{1'b1}}})) begin
                    accumulated_charge_ff  <= ACC_MAX;
                    charge_fraction_low_ff <= {FRAC_W{1'b1}};
                end else if (nxt_acc < $signed({3'b111, ACC_MIN, {FRAC_W{1'b0}}})) begin
                    accumulated_charge_ff  <= ACC_MIN;
                    charge_fraction_low_ff <= '0;
                end else begin
                    accumulated_charge_ff  <= nxt_acc[ACC_W-1:FRAC_W];
                    charge_fraction_low_ff <= nxt_acc[FRAC_W-1:0];
                end
            end
        end
    end

    assign offset_cal_req = acc_write;

    // periodic backup, counted in conversions
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            save_cnt_ff  <= '0;
            nv_save      <= 1'b0;
            nv_save_data <= '0;
        end else begin
            nv_save <= 1'b0;
            if (conv_done) begin
                if (save_cnt_ff >= 32'(SAVE_PERIOD - 1)) begin
                    save_cnt_ff  <= '0;
                    nv_save      <= 1'b1;
                    nv_save_data <= '{acc: accumulated_charge_ff, bias: accumulation_bias_ff};
                end else begin
                    save_cnt_ff <= save_cnt_ff + 32'h1;
                end
            end
        end
    end

    // plain configuration bytes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            control_ff             <= RESET_BYTE;
            current_offset_bias_ff <= RESET_BYTE;
            nominal_ff             <= '0;
            ae_frac_ff             <= RESET_BYTE;
            bp_ff[0]               <= TEMP_TOP;
            bp_ff[1]               <= TEMP_TOP;
            bp_ff[2]               <= TEMP_TOP;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_CONTROL: control_ff             <= reg_wdata;
                ADDR_COB:     current_offset_bias_ff <= reg_wdata;
                ADDR_NOM_MSB: nominal_ff[15:8]       <= reg_wdata;
                ADDR_NOM_LSB: nominal_ff[7:0]        <= reg_wdata;
                ADDR_AE_FRAC: ae_frac_ff             <= reg_wdata;
                // values above +40C are clipped to keep segment four anchored
                ADDR_BP12: bp_ff[0] <= ($signed(reg_wdata) > TEMP_TOP) ? TEMP_TOP : reg_wdata;
                ADDR_BP23: bp_ff[1] <= ($signed(reg_wdata) > TEMP_TOP) ? TEMP_TOP : reg_wdata;
                ADDR_BP34: bp_ff[2] <= ($signed(reg_wdata) > TEMP_TOP) ? TEMP_TOP : reg_wdata;
                default: ;
            endcase
        end
    end

    // slopes: curve c segment s at base + 4c + (s-1); full seg3 lands on 6d
    for (genvar i = 0; i < NUM_SLOPES; i++) begin : g_slope
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                slope_ff[i] <= RESET_BYTE;
            end else if (reg_wr && reg_addr == ADDR_SLOPE_BASE + 8'(i)) begin
                slope_ff[i] <= reg_wdata;
            end
        end
    end

    // register readback, one cycle after the read strobe
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_ff <= RESET_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CONTROL: reg_rdata_ff <= control_ff;
                ADDR_COB:     reg_rdata_ff <= current_offset_bias_ff;
                ADDR_BIAS:    reg_rdata_ff <= accumulation_bias_ff;
                ADDR_ACC_MSB: reg_rdata_ff <= accumulated_charge_ff[15:8];
                ADDR_ACC_LSB: reg_rdata_ff <= accumulated_charge_ff[7:0];
                ADDR_FRAC_HI: reg_rdata_ff <= charge_fraction_low_ff[FRAC_W-1:4];
                ADDR_FRAC_LO: reg_rdata_ff <= {charge_fraction_low_ff[3:0], 4'h0};
                ADDR_NOM_MSB: reg_rdata_ff <= nominal_ff[15:8];
                ADDR_NOM_LSB: reg_rdata_ff <= nominal_ff[7:0];
                ADDR_AE_FRAC: reg_rdata_ff <= ae_frac_ff;
                ADDR_BP12:    reg_rdata_ff <= bp_ff[0];
                ADDR_BP23:    reg_rdata_ff <= bp_ff[1];
                ADDR_BP34:    reg_rdata_ff <= bp_ff[2];
                default: begin
                    if (reg_addr >= ADDR_SLOPE_BASE && reg_addr < ADDR_SLOPE_BASE + 8'(NUM_SLOPES)) begin
                        reg_rdata_ff <= slope_ff[4'(reg_addr - ADDR_SLOPE_BASE)];
                    end else begin
                        reg_rdata_ff <= 8'h00;
                    end
                end
            endcase
        end
    end
    assign reg_rdata = reg_rdata_ff;

    // curve walker: one degree per cycle from +40C down to the present temperature
    walk_state_t       state_ff;
    logic signed [8:0] walk_t_ff;
    logic [1:0]        seg_idx;
    logic [SUM_W-1:0]  sum_ff [NUM_CURVES];
    logic [15:0]       cap_ff [NUM_CURVES];
    logic              walk_done;

    always_comb begin
        if (walk_t_ff > $signed({bp_ff[2][7], bp_ff[2]})) begin
            seg_idx = 2'h3;
        end else if (walk_t_ff > $signed({bp_ff[1][7], bp_ff[1]})) begin
            seg_idx = 2'h2;
        end else if (walk_t_ff > $signed({bp_ff[0][7], bp_ff[0]})) begin
            seg_idx = 2'h1;
        end else begin
            seg_idx = 2'h0;
        end
    end
    // at or above +40C the walk ends at once: segment five is flat
    assign walk_done = walk_t_ff <= $signed({temperature[7], temperature});

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff  <= WALK_IDLE;
            walk_t_ff <= '0;
        end else begin
            case (state_ff)
                WALK_IDLE: begin
                    walk_t_ff <= $signed({TEMP_TOP[7], TEMP_TOP});
                    state_ff  <= WALK_STEP;
                end
                WALK_STEP: begin
                    if (walk_done) begin
                        state_ff <= WALK_IDLE;
                    end else begin
                        walk_t_ff <= walk_t_ff - 9'sh001;
                    end
                end
                default: state_ff <= WALK_IDLE;
            endcase
        end
    end

    for (genvar c = 0; c < NUM_CURVES; c++) begin : g_curve
        logic [31:0] drop;
        logic [15:0] base;
        assign drop = (nominal_ff * sum_ff[c]) >> SLOPE_SHIFT;
        if (c == 0) begin : g_full
            assign base = nominal_ff;
        end else if (c == 1) begin : g_ae
            // widen before the product so the high bits survive the shift
            assign base = 16'((32'(nominal_ff) * 32'(ae_frac_ff)) >> 8);
        end else begin : g_se
            assign base = 16'h0000;
        end
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                sum_ff[c] <= '0;
                cap_ff[c] <= '0;
            end else if (state_ff == WALK_IDLE) begin
                sum_ff[c] <= '0;
            end else if (walk_done) begin
                // below the empty floor the capacity reads zero, never wraps
                cap_ff[c] <= (drop >= 32'(base)) ? 16'h0000 : base - drop[15:0];
            end else begin
                sum_ff[c] <= sum_ff[c] + SUM_W'(slope_ff[c*NUM_SEGS + int'(seg_idx)]);
            end
        end
    end
    assign curve_caps = '{full_cap: cap_ff[0], active_empty_cap: cap_ff[1],
                          standby_empty_cap: cap_ff[2]};

    a_accum_sat_top: assert property (@(posedge core_clk) disable iff (!resetn)
        restored_ff && conv_done && !acc_write && skip_ff == 2'h0
        && accumulated_charge_ff == ACC_MAX && !blanked[16] && !accumulation_bias_ff[7]
        |=> accumulated_charge_ff == ACC_MAX)
        else $error("accumulator wrapped past top");
    a_write_clears_frac: assert property (@(posedge core_clk) disable iff (!resetn)
        restored_ff && acc_write |=> charge_fraction_low_ff == '0
        && accumulated_charge_ff == {$past(acc_msb_hold_ff), $past(reg_wdata)})
        else $error("write did not load count and clear fraction");
    a_cal_on_write: assert property (@(posedge core_clk) disable iff (!resetn)
        offset_cal_req == (reg_wr && reg_addr == ADDR_ACC_LSB && msb_pending_ff))
        else $error("offset request not tied to accumulator write");
    // checker-side marker of the first conversion after a count write
    logic first_conv_ff;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) first_conv_ff <= 1'b0;
        else if (acc_write) first_conv_ff <= 1'b1;
        else if (conv_done) first_conv_ff <= 1'b0;
    end
    a_skip_first_conv: assert property (@(posedge core_clk) disable iff (!resetn)
        first_conv_ff && conv_done && !acc_write
        |=> $stable(accumulated_charge_ff) && $stable(charge_fraction_low_ff))
        else $error("first conversion after write was accumulated");
    a_charge_blank: assert property (@(posedge core_clk) disable iff (!resetn)
        measured > 17'sh00000 && measured < CHG_BLANK |-> blanked == 17'sh00000)
        else $error("small charge result not blanked");
    a_discharge_blank: assert property (@(posedge core_clk) disable iff (!resetn)
        measured < 17'sh00000 && measured > DIS_BLANK |-> (blanked == 17'sh00000) == negative_blank_enable)
        else $error("discharge blanking disagrees with enable");
    a_restore_nv: assert property (@(posedge core_clk) disable iff (!resetn)
        resetn && !restored_ff |=> accumulated_charge_ff == $past(nv_restore.acc)
        && accumulation_bias_ff == $past(nv_restore.bias))
        else $error("power-up restore missed");
    a_flat_above_top: assert property (@(posedge core_clk) disable iff (!resetn)
        state_ff == WALK_STEP && temperature >= TEMP_TOP && $stable(temperature)
        && walk_t_ff == 9'sh028 |=> state_ff == WALK_IDLE && $stable(sum_ff[0]))
        else $error("curve moved above top temperature");
    a_bp_range: assert property (@(posedge core_clk) disable iff (!resetn)
        bp_ff[0] <= TEMP_TOP && bp_ff[1] <= TEMP_TOP && bp_ff[2] <= TEMP_TOP)
        else $error("breakpoint above top temperature");
endmodule : charge_gauge
`default_nettype wire

// *** host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model
    import charge_gauge_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'hff;
        reg_wdata = 8'h00;
    end
    // idle bus shows inverted values so a stale address never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        // data stands until the next read strobe, so take it on the next edge
        @(posedge core_clk);
        d = reg_rdata;
    endtask : rd
    // both bytes, high first, a few cycles apart, far inside the window
    task automatic wr_count(input logic [15:0] v);
        wr(ADDR_ACC_MSB, v[15:8]);
        wr(ADDR_ACC_LSB, v[7:0]);
    endtask : wr_count
endmodule : host_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench
    import charge_gauge_pkg::*;
;
    logic              core_clk, resetn, reg_wr, reg_rd, conv_done, nv_save, offset_cal_req;
    logic [7:0]        reg_addr, reg_wdata, reg_rdata;
    logic [15:0]       raw_current;
    logic signed [7:0] temperature;
    nv_image_t         nv_restore, nv_save_data;
    curve_caps_t       curve_caps;
    int                n_fail, n_checks, n_cal, n_save, s0;
    charge_gauge #(.WR_WINDOW_CYCLES(50), .SAVE_PERIOD(4)) dut_u (
        .core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .conv_done(conv_done), .raw_current(raw_current), .temperature(temperature),
        .nv_restore(nv_restore), .nv_save(nv_save), .nv_save_data(nv_save_data),
        .offset_cal_req(offset_cal_req), .curve_caps(curve_caps));
    host_model host_u (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (offset_cal_req === 1'b1) n_cal++;
        if (nv_save === 1'b1) n_save++;
    end
    task automatic results();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_u.rd(a, d);
        `CHK(d, e)
    endtask : chk_rd
    // raw value is only valid with the strobe, so it is scrambled after
    task automatic conv(input logic [15:0] r);
        @(posedge core_clk);
        conv_done   <= 1'b1;
        raw_current <= r;
        @(posedge core_clk);
        conv_done   <= 1'b0;
        raw_current <= ~r;
    endtask : conv
    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        results();
    end
    initial begin
        resetn      = 1'b0;
        conv_done   = 1'b0;
        raw_current = 16'h0000;
        temperature = 8'sh32;
        nv_restore  = '{acc: 16'h1234, bias: 8'h10};
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk_rd(ADDR_ACC_MSB, 8'h12);
        chk_rd(ADDR_ACC_LSB, 8'h34);
        chk_rd(ADDR_BIAS, 8'h10);
        conv(16'h0000);
        chk_rd(ADDR_FRAC_HI, 8'h01);
        host_u.wr_count(16'h0000);
        chk_rd(ADDR_FRAC_HI, 8'h00);
        // counted after the pulse edge has passed, never in its own time step
        `CHK(n_cal, 1)
        conv(16'h0400);
        chk_rd(ADDR_ACC_LSB, 8'h00);
        chk_rd(ADDR_FRAC_HI, 8'h00);
        conv(16'h1000);
        chk_rd(ADDR_ACC_LSB, 8'h01);
        chk_rd(ADDR_FRAC_HI, 8'h01);
        host_u.wr(ADDR_BIAS, 8'h00);
        conv(16'h003f);
        chk_rd(ADDR_FRAC_HI, 8'h01);
        host_u.wr(ADDR_COB, 8'h01);
        conv(16'h003f);
        chk_rd(ADDR_FRAC_HI, 8'h05);
        host_u.wr(ADDR_COB, 8'h00);
        conv(16'hffff);
        chk_rd(ADDR_FRAC_LO, 8'hf0);
        host_u.wr(ADDR_CONTROL, 8'h01);
        conv(16'hffff);
        chk_rd(ADDR_FRAC_HI, 8'h04);
        conv(16'hfff0);
        chk_rd(ADDR_FRAC_HI, 8'h03);
        host_u.wr_count(16'h7fff);
        conv(16'h0000);
        conv(16'h7fff);
        chk_rd(ADDR_ACC_MSB, 8'h7f);
        chk_rd(ADDR_ACC_LSB, 8'hff);
        chk_rd(ADDR_FRAC_HI, 8'hff);
        host_u.wr_count(16'h8000);
        conv(16'h0000);
        conv(16'h8000);
        chk_rd(ADDR_ACC_MSB, 8'h80);
        chk_rd(ADDR_FRAC_HI, 8'h00);
        host_u.wr(ADDR_ACC_LSB, 8'h66);
        chk_rd(ADDR_ACC_LSB, 8'h00);
        host_u.wr(ADDR_ACC_MSB, 8'h55);
        repeat (60) @(posedge core_clk);
        host_u.wr(ADDR_ACC_LSB, 8'h66);
        chk_rd(ADDR_ACC_MSB, 8'h80);
        `CHK(n_cal, 3)
        s0 = n_save;
        repeat (4) conv(16'h0000);
        // one edge for the pulse, one more so the counter has settled
        repeat (2) @(posedge core_clk);
        `CHK(n_save - s0, 1)
        `CHK(nv_save_data.bias, 8'h00)
        `CHK(nv_save_data.acc, 16'h8000)
        host_u.wr(ADDR_BP34, 8'h50);
        chk_rd(ADDR_BP34, 8'h28);
        host_u.wr(ADDR_BP12, 8'hf4);
        host_u.wr(ADDR_BP23, 8'h00);
        host_u.wr(ADDR_BP34, 8'h12);
        host_u.wr(ADDR_NOM_MSB, 8'h10);
        host_u.wr(ADDR_NOM_LSB, 8'h00);
        host_u.wr(ADDR_AE_FRAC, 8'h80);
        host_u.wr(ADDR_FULL_SEG3, 8'h13);
        chk_rd(ADDR_BP12, 8'hf4);
        chk_rd(ADDR_FULL_SEG3, 8'h13);
        repeat (400) @(posedge core_clk);
        `CHK(curve_caps, {16'h1000, 16'h0800, 16'h0000})
        temperature <= 8'sh0a;
        repeat (400) @(posedge core_clk);
        `CHK(curve_caps, {16'h0fda, 16'h0800, 16'h0000})
        chk_rd(8'hff, 8'h00);
        results();
    end
endmodule : testbench
`default_nettype wire
